// >>> rtl/timer16_compare_phase_pwm.sv
// module: 16-bit timer with two compare units and phase-correct pwm
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module timer16_compare_phase_pwm #(
   parameter int PRESCALE = 1   // sys_clk cycles per timer clock
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdata,
   output logic             compareOutA,
   output logic             compareOutB,
   output logic             timerIrq
);
   // ==========================================
   // timer clock enable from a divider
   logic [15:0] preCnt_ff;
   logic        tick;
   logic        runEn;

   assign tick = runEn && (preCnt_ff == 16'(PRESCALE - 1));

   // divider restarts while the timer is halted
   always_ff @(posedge sys_clk) begin
      if (!resetn || !runEn || tick) begin
         preCnt_ff <= timer16_pkg::RST_WORD;
      end else begin
         preCnt_ff <= preCnt_ff + 16'h0001;
      end
   end

   // ==========================================
   // software control state
   logic [15:0] control_ff;
   logic [15:0] counter_value_ff;
   logic [15:0] compare_a_buf_ff;
   logic [15:0] compare_b_buf_ff;
   logic [15:0] compare_a_value_ff;
   logic [15:0] compare_b_value_ff;
   logic [15:0] capture_top_value_ff;
   logic [3:0]  irqEnable_ff;
   logic [3:0]  waveform_mode_sel;
   logic [1:0]  comSelA;
   logic [1:0]  comSelB;

   assign waveform_mode_sel = control_ff[timer16_pkg::CTL_WGM_LSB +: 4];
   assign comSelA           = control_ff[timer16_pkg::CTL_COMA_LSB +: 2];
   assign comSelB           = control_ff[timer16_pkg::CTL_COMB_LSB +: 2];
   assign runEn             = control_ff[timer16_pkg::CTL_RUN_BIT];

   // mode decode
   logic        phaseMode;
   logic        buffered;
   logic        fixedTop;
   logic [15:0] topValue;
   logic [15:0] resMask;

   always_comb begin
      phaseMode = 1'b0;
      fixedTop  = 1'b0;
      resMask   = timer16_pkg::TOP_MAX;
      topValue  = timer16_pkg::TOP_MAX;
      case (waveform_mode_sel)
         timer16_pkg::WGM_PC8: begin
            phaseMode = 1'b1;
            fixedTop  = 1'b1;
            topValue  = timer16_pkg::TOP_8BIT;
         end
         timer16_pkg::WGM_PC9: begin
            phaseMode = 1'b1;
            fixedTop  = 1'b1;
            topValue  = timer16_pkg::TOP_9BIT;
         end
         timer16_pkg::WGM_PC10: begin
            phaseMode = 1'b1;
            fixedTop  = 1'b1;
            topValue  = timer16_pkg::TOP_10BIT;
         end
         timer16_pkg::WGM_PC_CAP: begin
            phaseMode = 1'b1;
            topValue  = capture_top_value_ff;
         end
         timer16_pkg::WGM_PC_CMPA: begin
            phaseMode = 1'b1;
            topValue  = compare_a_value_ff;
         end
         timer16_pkg::WGM_CTC_A: begin
            topValue  = compare_a_value_ff;
         end
         timer16_pkg::WGM_CTC_CAP: begin
            topValue  = capture_top_value_ff;
         end
         default: begin
            topValue  = timer16_pkg::TOP_MAX;
         end
      endcase
      if (fixedTop) begin
         resMask = topValue;
      end
   end

   // normal and clear-on-match modes write straight through
   assign buffered = !(waveform_mode_sel == timer16_pkg::WGM_NORMAL
                    || waveform_mode_sel == timer16_pkg::WGM_CTC_A
                    || waveform_mode_sel == timer16_pkg::WGM_CTC_CAP);

   // register write decode
   logic wrControl;
   logic wrCounter;
   logic wrCmpA;
   logic wrCmpB;
   logic wrClear;

   assign wrControl = regWr && (regAddr == timer16_pkg::OFS_CONTROL);
   assign wrCounter = regWr && (regAddr == timer16_pkg::OFS_COUNTER);
   assign wrCmpA    = regWr && (regAddr == timer16_pkg::OFS_COMPARE_A);
   assign wrCmpB    = regWr && (regAddr == timer16_pkg::OFS_COMPARE_B);
   assign wrClear   = regWr && (regAddr == timer16_pkg::OFS_IRQ_CLEAR);

   // control, capture top and interrupt enable registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         control_ff           <= timer16_pkg::RST_WORD;
         capture_top_value_ff <= timer16_pkg::RST_WORD;
         irqEnable_ff         <= timer16_pkg::RST_FLAGS;
      end else if (regWr) begin
         case (regAddr)
            timer16_pkg::OFS_CONTROL:     control_ff <= {7'h00, regWdata[8:0]};
            timer16_pkg::OFS_CAPTURE_TOP: capture_top_value_ff <= regWdata;
            timer16_pkg::OFS_IRQ_ENABLE:  irqEnable_ff <= regWdata[3:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // counter: dual slope in phase-correct modes, else up to top
   logic countDown_ff;
   logic atTop;
   logic atBottom;
   logic turnAtTop;

   assign atTop     = (counter_value_ff == topValue);
   assign atBottom  = (counter_value_ff == timer16_pkg::RST_WORD);
   assign turnAtTop = tick && phaseMode && atTop && !countDown_ff;   // top seen on up slope

   // software write overrides counting
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         counter_value_ff <= timer16_pkg::RST_WORD;
         countDown_ff     <= 1'b0;
      end else if (wrCounter) begin
         counter_value_ff <= regWdata;
      end else if (tick) begin
         if (phaseMode) begin
            if (!countDown_ff && (counter_value_ff >= topValue)) begin
               countDown_ff     <= 1'b1;
               counter_value_ff <= counter_value_ff - 16'h0001;
            end else if (countDown_ff && atBottom) begin
               countDown_ff     <= 1'b0;
               counter_value_ff <= counter_value_ff + 16'h0001;
            end else if (countDown_ff) begin
               counter_value_ff <= counter_value_ff - 16'h0001;
            end else begin
               counter_value_ff <= counter_value_ff + 16'h0001;
            end
         end else begin
            countDown_ff     <= 1'b0;
            counter_value_ff <= atTop ? timer16_pkg::RST_WORD : counter_value_ff + 16'h0001;
         end
      end
   end

   // ==========================================
   // compare buffers: masked on write, moved to active at top in phase-correct modes
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         compare_a_buf_ff   <= timer16_pkg::RST_WORD;
         compare_b_buf_ff   <= timer16_pkg::RST_WORD;
         compare_a_value_ff <= timer16_pkg::RST_WORD;
         compare_b_value_ff <= timer16_pkg::RST_WORD;
      end else begin
         if (wrCmpA) begin
            compare_a_buf_ff <= regWdata & resMask;
         end
         if (wrCmpB) begin
            compare_b_buf_ff <= regWdata & resMask;
         end
         if (!buffered) begin
            if (wrCmpA) begin
               compare_a_value_ff <= regWdata & resMask;
            end
            if (wrCmpB) begin
               compare_b_value_ff <= regWdata & resMask;
            end
         end else if (turnAtTop) begin
            compare_a_value_ff <= compare_a_buf_ff;
            compare_b_value_ff <= compare_b_buf_ff;
         end
      end
   end

   // ==========================================
   // comparators
   logic matchA;
   logic matchB;

   assign matchA = tick && (counter_value_ff == compare_a_value_ff);
   assign matchB = tick && (counter_value_ff == compare_b_value_ff);

   // match registered, flag set one timer clock later
   logic matchAPend_ff;
   logic matchBPend_ff;

   // a halted timer drops its pending matches so a restart sets no stale flag
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         matchAPend_ff <= 1'b0;
         matchBPend_ff <= 1'b0;
      end else if (!runEn) begin
         matchAPend_ff <= 1'b0;
         matchBPend_ff <= 1'b0;
      end else if (tick) begin
         matchAPend_ff <= matchA;
         matchBPend_ff <= matchB;
      end
   end

   // ==========================================
   // interrupt flags: set wins over clear
   logic [3:0] flags_ff;
   logic [3:0] setEv;
   logic [3:0] clrEv;

   assign setEv[timer16_pkg::FLG_CMA] = (tick && matchAPend_ff)
      || (turnAtTop && waveform_mode_sel == timer16_pkg::WGM_PC_CMPA);
   assign setEv[timer16_pkg::FLG_CMB] = tick && matchBPend_ff;
   assign setEv[timer16_pkg::FLG_OVF] = tick && phaseMode && countDown_ff
      && (counter_value_ff == 16'h0001);
   assign setEv[timer16_pkg::FLG_CAP] = turnAtTop
      && waveform_mode_sel == timer16_pkg::WGM_PC_CAP;

   // clear by writing one, or by the serviced strobe named for each flag
   assign clrEv[timer16_pkg::FLG_OVF] = (wrClear && regWdata[timer16_pkg::FLG_OVF])
      || (wrControl && regWdata[timer16_pkg::CTL_SERVO_BIT]);
   assign clrEv[timer16_pkg::FLG_CMA] = (wrClear && regWdata[timer16_pkg::FLG_CMA])
      || (wrControl && regWdata[timer16_pkg::CTL_SERVA_BIT]);
   assign clrEv[timer16_pkg::FLG_CMB] = (wrClear && regWdata[timer16_pkg::FLG_CMB])
      || (wrControl && regWdata[timer16_pkg::CTL_SERVB_BIT]);
   assign clrEv[timer16_pkg::FLG_CAP] = (wrClear && regWdata[timer16_pkg::FLG_CAP])
      || (wrControl && regWdata[timer16_pkg::CTL_SERVC_BIT]);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flags_ff <= timer16_pkg::RST_FLAGS;
      end else begin
         flags_ff <= (flags_ff & ~clrEv) | setEv;
      end
   end

   assign timerIrq = |(flags_ff & irqEnable_ff);

   // ==========================================
   // waveform generator for each compare pin
   logic nxt_outA;
   logic nxt_outB;
   logic outA_ff;
   logic outB_ff;

   function automatic logic wave(input logic [1:0] sel, input logic cur, input logic hit,
                                 input logic pc, input logic down, input logic wrap);
      logic v;
      v = cur;
      if (hit) begin
         case (sel)
            timer16_pkg::COM_TOGGLE: v = pc ? cur : ~cur;
            timer16_pkg::COM_NONINV: v = pc ? down : 1'b0;
            timer16_pkg::COM_INV:    v = pc ? ~down : 1'b1;
            default:                 v = cur;
         endcase
      end else if (wrap && !pc) begin
         v = (sel == timer16_pkg::COM_NONINV) ? 1'b1 : (sel == timer16_pkg::COM_INV) ? 1'b0 : cur;
      end
      return v;
   endfunction : wave

   logic wrapEv;
   assign wrapEv = tick && !phaseMode && buffered && atTop;

   // pin level changes on the match timer clock; top counts as the down slope
   always_comb begin
      nxt_outA = wave(comSelA, outA_ff, matchA, phaseMode, countDown_ff || atTop, wrapEv);
      nxt_outB = wave(comSelB, outB_ff, matchB, phaseMode, countDown_ff || atTop, wrapEv);
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         outA_ff <= 1'b0;
         outB_ff <= 1'b0;
      end else begin
         outA_ff <= nxt_outA;
         outB_ff <= nxt_outB;
      end
   end

   assign compareOutA = (comSelA == timer16_pkg::COM_OFF) ? 1'b0 : outA_ff;
   assign compareOutB = (comSelB == timer16_pkg::COM_OFF) ? 1'b0 : outB_ff;

   // ==========================================
   // read data, one cycle after the read strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         regRdata <= timer16_pkg::RST_WORD;
      end else if (regRd) begin
         case (regAddr)
            timer16_pkg::OFS_CONTROL:     regRdata <= control_ff;
            timer16_pkg::OFS_COUNTER:     regRdata <= counter_value_ff;
            timer16_pkg::OFS_COMPARE_A:   regRdata <= compare_a_buf_ff;
            timer16_pkg::OFS_COMPARE_B:   regRdata <= compare_b_buf_ff;
            timer16_pkg::OFS_CAPTURE_TOP: regRdata <= capture_top_value_ff;
            timer16_pkg::OFS_IRQ_STATUS:  regRdata <= {12'h000, flags_ff};
            timer16_pkg::OFS_IRQ_ENABLE:  regRdata <= {12'h000, irqEnable_ff};
            default:                      regRdata <= timer16_pkg::RST_WORD;
         endcase
      end else begin
         regRdata <= timer16_pkg::RST_WORD;
      end
   end
endmodule : timer16_compare_phase_pwm

// >>> rtl/timer16_pkg.sv
// package: register map, field layout, reset values and mode codes of the 16-bit pwm timer
package timer16_pkg;
   // ==========================================
   // register offsets (word index on the plain port)
   localparam logic [3:0] OFS_CONTROL     = 4'h0;
   localparam logic [3:0] OFS_COUNTER     = 4'h1;
   localparam logic [3:0] OFS_COMPARE_A   = 4'h2;
   localparam logic [3:0] OFS_COMPARE_B   = 4'h3;
   localparam logic [3:0] OFS_CAPTURE_TOP = 4'h4;
   localparam logic [3:0] OFS_IRQ_STATUS  = 4'h5;
   localparam logic [3:0] OFS_IRQ_CLEAR   = 4'h6;
   localparam logic [3:0] OFS_IRQ_ENABLE  = 4'h7;
   // ==========================================
   // control register fields
   localparam int CTL_WGM_LSB   = 0;   // waveform_mode_sel, 4 bits
   localparam int CTL_COMA_LSB  = 4;   // compare_output_sel of unit a, 2 bits
   localparam int CTL_COMB_LSB  = 6;   // compare_output_sel of unit b, 2 bits
   localparam int CTL_RUN_BIT   = 8;   // timer clock running
   localparam int CTL_SERVA_BIT = 9;   // interrupt-serviced strobes (write only)
   localparam int CTL_SERVB_BIT = 10;
   localparam int CTL_SERVO_BIT = 11;
   localparam int CTL_SERVC_BIT = 12;
   // ==========================================
   // status bit positions
   localparam int FLG_OVF = 0;   // overflow_flag
   localparam int FLG_CMA = 1;   // compare_match_flag a
   localparam int FLG_CMB = 2;   // compare_match_flag b
   localparam int FLG_CAP = 3;   // capture_flag
   localparam int FLG_NUM = 4;
   // ==========================================
   // reset values
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [3:0]  RST_FLAGS = 4'h0;
   // ==========================================
   // waveform modes and fixed tops
   localparam logic [3:0]  WGM_NORMAL   = 4'h0;
   localparam logic [3:0]  WGM_PC8      = 4'h1;
   localparam logic [3:0]  WGM_PC9      = 4'h2;
   localparam logic [3:0]  WGM_PC10     = 4'h3;
   localparam logic [3:0]  WGM_CTC_A    = 4'h4;
   localparam logic [3:0]  WGM_PC_CAP   = 4'ha;
   localparam logic [3:0]  WGM_PC_CMPA  = 4'hb;
   localparam logic [3:0]  WGM_CTC_CAP  = 4'hc;
   localparam logic [15:0] TOP_8BIT     = 16'h00ff;
   localparam logic [15:0] TOP_9BIT     = 16'h01ff;
   localparam logic [15:0] TOP_10BIT    = 16'h03ff;
   localparam logic [15:0] TOP_MAX      = 16'hffff;
   localparam logic [15:0] TOP_MIN      = 16'h0003;
   // compare output settings
   localparam logic [1:0]  COM_OFF      = 2'h0;
   localparam logic [1:0]  COM_TOGGLE   = 2'h1;
   localparam logic [1:0]  COM_NONINV   = 2'h2;
   localparam logic [1:0]  COM_INV      = 2'h3;
endpackage : timer16_pkg

// >>> verification/tb_timer16_compare_phase_pwm.sv
// testbench: register-port scenarios for the 16-bit phase-correct pwm timer
`timescale 1ns/1ps
module tb_timer16_compare_phase_pwm;
   logic        sys_clk;
   logic        resetn;
   logic [3:0]  regAddr;
   logic [15:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [15:0] regRdata;
   logic        compareOutA;
   logic        compareOutB;
   logic        timerIrq;
   int          mismatches;
   int          comparisons;
   logic [15:0] smp [0:599];
   logic [1:0]  pins [0:599];
   logic [15:0] msk [1:4] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'hffff};
   localparam logic [15:0] CMP_B = 16'h0002;   // compare b level of every pc run

   timer16_compare_phase_pwm #(.PRESCALE(1)) i_timer16_compare_phase_pwm (
      .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .compareOutA(compareOutA),
      .compareOutB(compareOutB), .timerIrq(timerIrq));

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   // ==========================================
   // bus and compare helpers
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask : rd

   // back-to-back counter reads, one sample per cycle with both pins
   task stream(input int n);
      @(posedge sys_clk);
      regRd   <= 1'b1;
      regAddr <= timer16_pkg::OFS_COUNTER;
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         if (i == n - 1) regRd <= 1'b0;   // last strobe ends on the edge that takes it
         #1 smp[i] = regRdata;
         pins[i] = {compareOutA, compareOutB};
      end
   endtask : stream

   task pcRun(input logic [3:0] m, input logic [1:0] selB, input logic [15:0] top,
              input int n, input logic [15:0] st);
      logic [15:0] maxV;
      logic [2:0]  seen;
      logic        armed;
      logic        expB;
      maxV  = 16'h0000;
      seen  = 3'b000;
      armed = 1'b0;
      expB  = 1'b0;
      wr(timer16_pkg::OFS_CONTROL, {12'h000, m});
      wr(timer16_pkg::OFS_COUNTER, 16'h0000);
      wr(timer16_pkg::OFS_IRQ_CLEAR, 16'h000f);
      wr(timer16_pkg::OFS_CONTROL, {7'h00, 1'b1, selB, 2'h0, m});
      stream(n);
      for (int i = 3; i < n; i++) begin
         if (smp[i] > maxV) maxV = smp[i];
         seen = seen | {pins[i][1], pins[i][0], !pins[i][0]};
         chk({15'h0, (smp[i] - smp[i-1] == 16'h1) || (smp[i-1] - smp[i] == 16'h1)},
             16'h1);
         // pin b: low after an up-slope match, high after a down-slope one, inverted on request
         expB = (smp[i] < CMP_B) || (smp[i] == CMP_B && smp[i-1] > smp[i]);
         expB = expB ^ (selB == timer16_pkg::COM_INV);
         if (smp[i] == CMP_B) armed = 1'b1;
         if (armed) chk({15'h0, pins[i][0]}, {15'h0, expB});
      end
      chk(maxV, top);
      chk({13'h0, seen}, 16'h0003);
      wr(timer16_pkg::OFS_CONTROL, {12'h000, m});
      repeat (3) @(posedge sys_clk);
      rd(timer16_pkg::OFS_IRQ_STATUS, st);
   endtask : pcRun

   // ==========================================
   // scenarios
   task testResetValues();
      wr(4'h8, 16'h1234);
      for (int a = 0; a < 9; a++) rd(a[3:0], 16'h0000);
      $display("test reset_values done");
   endtask : testResetValues

   task testMasking();
      for (int m = 1; m < 5; m++) begin
         wr(timer16_pkg::OFS_CONTROL, {12'h000, m[3:0]});
         wr(timer16_pkg::OFS_COMPARE_A, 16'hffff);
         wr(timer16_pkg::OFS_COMPARE_B, 16'hffff);
         rd(timer16_pkg::OFS_COMPARE_A, msk[m]);
         rd(timer16_pkg::OFS_COMPARE_B, msk[m]);
      end
      $display("test masking done");
   endtask : testMasking

   task testPhaseCorrect();
      wr(timer16_pkg::OFS_CONTROL, {12'h000, timer16_pkg::WGM_CTC_A});
      wr(timer16_pkg::OFS_COMPARE_A, 16'h0003);
      wr(timer16_pkg::OFS_COMPARE_B, CMP_B);
      wr(timer16_pkg::OFS_CAPTURE_TOP, 16'h0005);
      pcRun(timer16_pkg::WGM_PC_CMPA, timer16_pkg::COM_NONINV, 16'h0003, 30, 16'h0007);
      pcRun(timer16_pkg::WGM_PC8, timer16_pkg::COM_NONINV, 16'h00ff, 600, 16'h0007);
      pcRun(timer16_pkg::WGM_PC_CAP, timer16_pkg::COM_INV, 16'h0005, 40, 16'h000f);
      $display("test phase_correct done");
   endtask : testPhaseCorrect

   task testIrq();
      wr(timer16_pkg::OFS_IRQ_ENABLE, 16'h0000);
      #1 chk({15'h0, timerIrq}, 16'h0000);
      wr(timer16_pkg::OFS_IRQ_ENABLE, 16'h0002);
      #1 chk({15'h0, timerIrq}, 16'h0001);
      wr(timer16_pkg::OFS_IRQ_CLEAR, 16'h0002);
      #1 chk({15'h0, timerIrq}, 16'h0000);
      rd(timer16_pkg::OFS_IRQ_STATUS, 16'h000d);
      wr(timer16_pkg::OFS_IRQ_ENABLE, 16'h0001);
      #1 chk({15'h0, timerIrq}, 16'h0001);
      wr(timer16_pkg::OFS_CONTROL, (16'h1 << timer16_pkg::CTL_SERVO_BIT) | 16'h000a);
      rd(timer16_pkg::OFS_IRQ_STATUS, 16'h000c);
      chk({15'h0, timerIrq}, 16'h0000);
      rd(timer16_pkg::OFS_CONTROL, 16'h000a);
      wr(timer16_pkg::OFS_IRQ_CLEAR, 16'h000f);
      rd(timer16_pkg::OFS_IRQ_STATUS, 16'h0000);
      rd(timer16_pkg::OFS_IRQ_CLEAR, 16'h0000);
      $display("test irq done");
   endtask : testIrq

   // ==========================================
   // verdict and end of run
   task summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // main sequence
   initial begin
      sys_clk     = 1'b0;
      resetn      = 1'b0;
      regAddr     = 4'h0;
      regWdata    = 16'h0000;
      regWr       = 1'b0;
      regRd       = 1'b0;
      mismatches  = 0;
      comparisons = 0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      testResetValues();
      testMasking();
      testPhaseCorrect();
      testIrq();
      summarize();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      $display("watchdog expired");
      summarize();
   end
endmodule : tb_timer16_compare_phase_pwm

// >>> verification/timer16_props.sv
// checker: port-level properties of the 16-bit phase-correct pwm timer
`timescale 1ns/1ps
module timer16_props #(
   parameter int PRESCALE = 1
) (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic [3:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [15:0] regRdata,
   input wire logic        compareOutA,
   input wire logic        compareOutB,
   input wire logic        timerIrq
);
   logic [15:0] ctlSh;
   logic [3:0]  enSh;
   logic [15:0] expA;
   logic        expAOk;
   logic        cntWr;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // ==========================================
   // resolution mask applied to compare writes
   function automatic logic [15:0] fixMask(input logic [3:0] m);
      case (m)
         4'h1:    return timer16_pkg::TOP_8BIT;
         4'h2:    return timer16_pkg::TOP_9BIT;
         4'h3:    return timer16_pkg::TOP_10BIT;
         default: return 16'hffff;
      endcase
   endfunction : fixMask

   // shadow of the registers software has written
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctlSh  <= 16'h0000;
         enSh   <= 4'h0;
         expA   <= 16'h0000;
         expAOk <= 1'b0;
         cntWr  <= 1'b0;
      end else if (regWr) begin
         case (regAddr)
            timer16_pkg::OFS_CONTROL: begin
               ctlSh <= regWdata;
               cntWr <= 1'b0;
            end
            timer16_pkg::OFS_COUNTER: cntWr <= 1'b1;
            timer16_pkg::OFS_COMPARE_A: begin
               expA   <= regWdata & fixMask(ctlSh[3:0]);
               expAOk <= (ctlSh[3:0] <= 4'h4);
            end
            timer16_pkg::OFS_IRQ_ENABLE: enSh <= regWdata[3:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // properties
   sequence stopped3;
      (!ctlSh[timer16_pkg::CTL_RUN_BIT])[*3];
   endsequence
   sequence clearAll;
      regWr && (regAddr == timer16_pkg::OFS_IRQ_CLEAR) && (regWdata[3:0] == 4'hf);
   endsequence

   a_rd_idle_zero: assert property (!$past(regRd) |-> regRdata == 16'h0000)
      else $error("read data not zero outside read answer");
   a_unmapped_reads_zero: assert property (regRd && regAddr > 4'h7 |=> regRdata == 16'h0000)
      else $error("unmapped read not zero");
   a_serv_bits_wo: assert property (
      regRd && regAddr == timer16_pkg::OFS_CONTROL |=> regRdata[15:9] == 7'h00)
      else $error("serviced strobes read back");
   a_clear_reg_wo: assert property (
      regRd && regAddr == timer16_pkg::OFS_IRQ_CLEAR |=> regRdata == 16'h0000)
      else $error("clear register read back");
   a_cmpa_masked: assert property (
      regRd && regAddr == timer16_pkg::OFS_COMPARE_A && expAOk |=> regRdata == expA)
      else $error("compare a value not masked as written");
   a_irq_needs_enable: assert property (enSh == 4'h0 |-> !timerIrq)
      else $error("interrupt with all enables low");
   a_outa_gated: assert property (
      (ctlSh[5:4] == timer16_pkg::COM_OFF)[*3] |-> !compareOutA)
      else $error("compare output a driven while off");
   a_outb_gated: assert property (
      (ctlSh[7:6] == timer16_pkg::COM_OFF)[*3] |-> !compareOutB)
      else $error("compare output b driven while off");
   a_pc_count_bound: assert property (
      regRd && regAddr == timer16_pkg::OFS_COUNTER && !cntWr
      && ctlSh[3:0] == timer16_pkg::WGM_PC8 |=> regRdata <= timer16_pkg::TOP_8BIT)
      else $error("counter above fixed top");
   a_clear_drops_irq: assert property (stopped3 ##0 clearAll |=> !timerIrq)
      else $error("interrupt stays after clearing all flags");
endmodule : timer16_props

bind timer16_compare_phase_pwm timer16_props #(.PRESCALE(PRESCALE)) i_timer16_props (
   .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .compareOutA(compareOutA),
   .compareOutB(compareOutB), .timerIrq(timerIrq));
